// >>> core/usbdb_pkg.sv
// Shared constants and types of the double-buffered endpoint block
package usbdb_pkg;

    // ************************************************************
    // Packet storage geometry
    // ************************************************************
    localparam int          PKT_MAX     = 8;    // Bytes per packet slot
    localparam int          PTR_W       = 3;    // Byte index inside a slot
    localparam int          LEN_W       = 4;    // Byte count 0..PKT_MAX
    localparam int          FIFO_DEPTH  = 8;    // Receive FIFO words
    localparam int          FIFO_WIDTH  = 9;    // Data byte plus last flag
    localparam int          FIFO_LAST   = 8;    // Position of last flag

    // ************************************************************
    // Query status byte layout
    // ************************************************************
    localparam int          ST_FULL_BIT  = 0;   // Active slot full
    localparam int          ST_ACT_BIT   = 1;   // Index of active slot
    localparam int          ST_OTHER_BIT = 2;   // Other slot full
    localparam int          ST_INT_BIT   = 3;   // Endpoint interrupt flag

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic        ACT_RST     = 1'b0;  // First buffer active
    localparam logic [1:0]  FULL_RST    = 2'h0;  // Both slots empty
    localparam logic [7:0]  STATUS_RST  = 8'h00; // Query byte at reset

    // Link-side sequencer states
    typedef enum logic [2:0] {
        LS_IDLE,    // Waiting for a token
        LS_RX,      // Storing an accepted OUT packet
        LS_DROP,    // Discarding a refused OUT packet
        LS_TX,      // Streaming an IN packet
        LS_WAIT     // Waiting for the host handshake
    } usbdb_state_e;

endpackage : usbdb_pkg

// >>> core/usbdb_core.sv
// Receive FIFO and the double-buffered endpoint engine
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Receive FIFO between the link and the packet slots
// ****************************************************************
module usbdb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];        // Storage words
    logic [AW-1:0]    rd_r, rd_nxt;       // Read pointer
    logic [AW-1:0]    wr_r, wr_nxt;       // Write pointer
    logic [AW:0]      cnt_r, cnt_nxt;     // Fill level
    logic             ready_r, ready_nxt; // Registered not full
    logic             empty_r, empty_nxt; // Registered empty
    logic             push, pop;          // Accepted transfers

    assign in_ready  = ready_r;
    assign out_valid = ~empty_r;
    assign out_data  = mem[rd_r];

    // Next pointers and flags; registered flags keep ready glitch-free
    always_comb
    begin
        push      = in_valid & ready_r;
        pop       = out_ready & ~empty_r;
        rd_nxt    = pop ? rd_r + AW'(1) : rd_r;
        wr_nxt    = push ? wr_r + AW'(1) : wr_r;
        cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
        empty_nxt = (cnt_nxt == '0);
    end

    // Pointer and flag registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_r    <= '0;
            wr_r    <= '0;
            cnt_r   <= '0;
            ready_r <= 1'b1;
            empty_r <= 1'b1;
        end
        else
        begin
            rd_r    <= rd_nxt;
            wr_r    <= wr_nxt;
            cnt_r   <= cnt_nxt;
            ready_r <= ready_nxt;
            empty_r <= empty_nxt;
        end
    end

    // Storage write; no reset needed for data words
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_r] <= in_data;
    end

endmodule : usbdb_fifo

// ****************************************************************
// Double-buffered endpoint engine
// ****************************************************************
module usbdb_top
(
    input  wire logic                   CLK_SYS,
    input  wire logic                   RESETN,
    input  wire logic                   EP_ISO,
    input  wire logic                   EP_DIR_IN,
    input  wire logic                   NAK_INT_EN,
    input  wire logic                   FRAME_TICK,
    input  wire logic                   LNK_OUT_START,
    input  wire logic                   LNK_OUT_VALID,
    input  wire logic [7:0]             LNK_OUT_DATA,
    input  wire logic                   LNK_OUT_LAST,
    output logic                        LNK_OUT_READY,
    input  wire logic                   LNK_IN_TOKEN,
    input  wire logic                   LNK_IN_DONE,
    input  wire logic                   LNK_IN_FAIL,
    output logic                        LNK_ACK,
    output logic                        LNK_NAK,
    output logic                        LNK_IN_VALID,
    output logic [7:0]                  LNK_IN_DATA,
    output logic                        LNK_IN_LAST,
    output logic                        LNK_IN_ZLP,
    input  wire logic                   CPU_WR,
    input  wire logic [7:0]             CPU_WDATA,
    input  wire logic                   CPU_RD,
    output logic [7:0]                  CPU_RDATA,
    output logic [usbdb_pkg::LEN_W-1:0] CPU_RLEN,
    input  wire logic                   CPU_CMD_RELEASE,
    input  wire logic                   CPU_CMD_COMMIT,
    input  wire logic                   CPU_CMD_QUERY,
    output logic [7:0]                  CPU_STATUS,
    input  wire logic                   CPU_INT_CLR,
    output logic                        EP_INT
);
    import usbdb_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]       buf_mem [2][PKT_MAX]; // Two packet slots
    logic             act_r, act_nxt;       // Active slot index
    logic [1:0]       full_r, full_nxt;     // Slot holds a packet
    logic [LEN_W-1:0] len_r [2];            // Packet length per slot
    logic [LEN_W-1:0] len_nxt [2];
    logic [LEN_W-1:0] cptr_r, cptr_nxt;     // CPU byte index
    logic [LEN_W-1:0] lcnt_r, lcnt_nxt;     // Link byte index
    logic             tgt_r, tgt_nxt;       // Slot used by the link
    logic             txp_r, txp_nxt;       // Oldest committed IN slot
    usbdb_state_e     st_r, st_nxt;         // Link sequencer
    logic             int_r, int_nxt;
    logic             ack_r, ack_nxt;
    logic             nak_r, nak_nxt;
    logic             ival_r, ival_nxt;
    logic [7:0]       idat_r, idat_nxt;
    logic             ilast_r, ilast_nxt;
    logic             zlp_r, zlp_nxt;
    logic [7:0]       rdat_r, rdat_nxt;
    logic [LEN_W-1:0] rlen_r, rlen_nxt;
    logic [7:0]       stat_r, stat_nxt;
    logic             mwe;                  // Slot memory write
    logic             mslot;
    logic [PTR_W-1:0] maddr;
    logic [7:0]       mwd;
    logic             f_valid, f_ready;     // FIFO drain handshake
    logic [FIFO_WIDTH-1:0] f_data;
    logic             f_pop;

    // Slot that the next OUT packet lands in
    function automatic logic rx_slot(input logic iso, input logic act,
                                     input logic [1:0] full);
        // Isochronous traffic always uses the non-active slot
        if (iso)
            rx_slot = ~act;
        else
            rx_slot = full[act] ? ~act : act;
    endfunction : rx_slot

    // ************************************************************
    // Receive FIFO
    // ************************************************************
    // Drain stalls on a CPU write since the slot memory has one port;
    // the stall backs up into LNK_OUT_READY
    assign f_ready = ~CPU_WR;

    usbdb_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RESETN),
        .in_valid  (LNK_OUT_VALID),
        .in_data   ({LNK_OUT_LAST, LNK_OUT_DATA}),
        .in_ready  (LNK_OUT_READY),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        act_nxt   = act_r;
        full_nxt  = full_r;
        len_nxt   = len_r;
        cptr_nxt  = cptr_r;
        lcnt_nxt  = lcnt_r;
        tgt_nxt   = tgt_r;
        txp_nxt   = txp_r;
        st_nxt    = st_r;
        int_nxt   = int_r & ~CPU_INT_CLR;  // Packet-end sets below win the clear; NAK sets only fire while int_r is low and also win it
        ack_nxt   = 1'b0;
        nak_nxt   = 1'b0;
        ival_nxt  = 1'b0;
        idat_nxt  = idat_r;
        ilast_nxt = 1'b0;
        zlp_nxt   = 1'b0;
        rdat_nxt  = rdat_r;
        rlen_nxt  = len_r[act_r];
        stat_nxt  = stat_r;
        mwe       = 1'b0;
        mslot     = act_r;
        maddr     = cptr_r[PTR_W-1:0];
        mwd       = CPU_WDATA;
        f_pop     = f_valid & f_ready;

        // CPU data access always targets the active slot
        if (CPU_WR && cptr_r < LEN_W'(PKT_MAX))
        begin
            mwe      = 1'b1;
            cptr_nxt = cptr_r + LEN_W'(1);
        end
        else if (CPU_RD && cptr_r < LEN_W'(PKT_MAX))
        begin
            rdat_nxt = buf_mem[act_r][cptr_r[PTR_W-1:0]];
            cptr_nxt = cptr_r + LEN_W'(1);
        end

        // Query reports the state seen before this cycle's commands
        if (CPU_CMD_QUERY)
        begin
            stat_nxt               = 8'h00;
            stat_nxt[ST_FULL_BIT]  = full_r[act_r];
            stat_nxt[ST_ACT_BIT]   = act_r;
            stat_nxt[ST_OTHER_BIT] = full_r[~act_r];
            stat_nxt[ST_INT_BIT]   = int_r;
        end

        // Release frees the slot; bulk also swaps slots
        if (CPU_CMD_RELEASE)
        begin
            full_nxt[act_r] = 1'b0;
            cptr_nxt        = '0;
            if (!EP_ISO)
                act_nxt = ~act_r;
        end
        else if (CPU_CMD_COMMIT)
        begin
            full_nxt[act_r] = 1'b1;
            len_nxt[act_r]  = cptr_r;
            cptr_nxt        = '0;
            if (!EP_ISO)
                act_nxt = ~act_r;
        end

        // Frame boundary swaps isochronous slots
        if (EP_ISO && FRAME_TICK)
        begin
            act_nxt  = ~act_r;
            cptr_nxt = '0;
            if (!EP_DIR_IN)
                full_nxt[act_r] = 1'b0;
            else if (!full_r[act_r])
                zlp_nxt = 1'b1;
        end

        // Link sequencer
        case (st_r)
            LS_IDLE:
            begin
                if (LNK_OUT_START)
                begin
                    tgt_nxt  = rx_slot(EP_ISO, act_r, full_r);
                    lcnt_nxt = '0;
                    // Isochronous OUT overwrites whatever is there
                    if (EP_ISO || !full_r[tgt_nxt])
                    begin
                        ack_nxt = 1'b1;
                        st_nxt  = LS_RX;
                    end
                    else
                    begin
                        nak_nxt = 1'b1;
                        st_nxt  = LS_DROP;
                        if (NAK_INT_EN && !int_r)
                            int_nxt = 1'b1;
                    end
                end
                else if (LNK_IN_TOKEN)
                begin
                    tgt_nxt  = EP_ISO ? ~act_r : txp_r;
                    lcnt_nxt = '0;
                    if (full_r[tgt_nxt] && len_r[tgt_nxt] != '0)
                        st_nxt = LS_TX;
                    else if (full_r[tgt_nxt] || EP_ISO)
                    begin
                        // Empty committed packet or idle isochronous slot
                        zlp_nxt = 1'b1;
                        st_nxt  = full_r[tgt_nxt] ? LS_WAIT : LS_IDLE;
                    end
                    else
                    begin
                        nak_nxt = 1'b1;
                        if (NAK_INT_EN && !int_r)
                            int_nxt = 1'b1;
                    end
                end
            end
            LS_RX:
            begin
                if (f_pop)
                begin
                    // Bytes beyond a full slot are dropped, not wrapped
                    if (lcnt_r < LEN_W'(PKT_MAX))
                    begin
                        mwe      = 1'b1;
                        mslot    = tgt_r;
                        maddr    = lcnt_r[PTR_W-1:0];
                        mwd      = f_data[7:0];
                        lcnt_nxt = lcnt_r + LEN_W'(1);
                    end
                    if (f_data[FIFO_LAST])
                    begin
                        full_nxt[tgt_r] = 1'b1;
                        len_nxt[tgt_r]  = lcnt_nxt;
                        st_nxt          = LS_IDLE;
                        if (!EP_ISO)
                            int_nxt = 1'b1;
                    end
                end
            end
            LS_DROP:
            begin
                if (f_pop && f_data[FIFO_LAST])
                    st_nxt = LS_IDLE;
            end
            LS_TX:
            begin
                ival_nxt  = 1'b1;
                idat_nxt  = buf_mem[tgt_r][lcnt_r[PTR_W-1:0]];
                lcnt_nxt  = lcnt_r + LEN_W'(1);
                ilast_nxt = (lcnt_nxt == len_r[tgt_r]);
                if (ilast_nxt)
                    st_nxt = LS_WAIT;
            end
            LS_WAIT:
            begin
                if (LNK_IN_DONE)
                begin
                    full_nxt[tgt_r] = 1'b0;
                    st_nxt          = LS_IDLE;
                    if (!EP_ISO)
                    begin
                        txp_nxt = ~txp_r;
                        int_nxt = 1'b1;
                    end
                end
                else if (LNK_IN_FAIL)
                    st_nxt = LS_IDLE;                    // Retry on next IN
            end
            default:
                st_nxt = LS_IDLE;
        endcase
    end

    // ************************************************************
    // State registers
    // ************************************************************
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            act_r   <= ACT_RST;
            full_r  <= FULL_RST;
            len_r   <= '{default: '0};
            cptr_r  <= '0;
            lcnt_r  <= '0;
            tgt_r   <= ACT_RST;
            txp_r   <= ACT_RST;
            st_r    <= LS_IDLE;
            int_r   <= 1'b0;
            ack_r   <= 1'b0;
            nak_r   <= 1'b0;
            ival_r  <= 1'b0;
            idat_r  <= 8'h00;
            ilast_r <= 1'b0;
            zlp_r   <= 1'b0;
            rdat_r  <= 8'h00;
            rlen_r  <= '0;
            stat_r  <= STATUS_RST;
        end
        else
        begin
            act_r   <= act_nxt;
            full_r  <= full_nxt;
            len_r   <= len_nxt;
            cptr_r  <= cptr_nxt;
            lcnt_r  <= lcnt_nxt;
            tgt_r   <= tgt_nxt;
            txp_r   <= txp_nxt;
            st_r    <= st_nxt;
            int_r   <= int_nxt;
            ack_r   <= ack_nxt;
            nak_r   <= nak_nxt;
            ival_r  <= ival_nxt;
            idat_r  <= idat_nxt;
            ilast_r <= ilast_nxt;
            zlp_r   <= zlp_nxt;
            rdat_r  <= rdat_nxt;
            rlen_r  <= rlen_nxt;
            stat_r  <= stat_nxt;
        end
    end

    // Slot memory write port
    always_ff @(posedge CLK_SYS)
    begin
        if (mwe)
            buf_mem[mslot][maddr] <= mwd;
    end

    // Outputs straight from registers
    assign LNK_ACK      = ack_r;
    assign LNK_NAK      = nak_r;
    assign LNK_IN_VALID = ival_r;
    assign LNK_IN_DATA  = idat_r;
    assign LNK_IN_LAST  = ilast_r;
    assign LNK_IN_ZLP   = zlp_r;
    assign CPU_RDATA    = rdat_r;
    assign CPU_RLEN     = rlen_r;
    assign CPU_STATUS   = stat_r;
    assign EP_INT       = int_r;

endmodule : usbdb_top

`default_nettype wire

// >>> test/usbdb_chk_sva.sv
// Port-level assertions for the double-buffered endpoint block
`timescale 1ns/100ps
`default_nettype none
module usbdb_chk (
    input wire logic       CLK_SYS,
    input wire logic       RESETN,
    input wire logic       EP_ISO,
    input wire logic       EP_DIR_IN,
    input wire logic       NAK_INT_EN,
    input wire logic       FRAME_TICK,
    input wire logic       LNK_OUT_START,
    input wire logic       LNK_IN_TOKEN,
    input wire logic       CPU_CMD_QUERY,
    input wire logic       CPU_INT_CLR,
    input wire logic       LNK_ACK,
    input wire logic       LNK_NAK,
    input wire logic       LNK_IN_VALID,
    input wire logic       LNK_IN_LAST,
    input wire logic       LNK_IN_ZLP,
    input wire logic [7:0] CPU_STATUS,
    input wire logic       EP_INT
);
    // ************************************************************
    // One clock domain, so one default clock and reset
    // ************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // A byte of an IN packet that is not the final one
    sequence s_mid_byte;
        LNK_IN_VALID && !LNK_IN_LAST;
    endsequence

    a_ack_nak_excl: assert property (!(LNK_ACK && LNK_NAK))
        else $error("ack and nak together");
    a_ack_cause: assert property (LNK_ACK |->
        $past(LNK_OUT_START) && !EP_DIR_IN) else $error("stray ack");
    a_nak_cause: assert property (LNK_NAK |->
        $past(LNK_OUT_START) || $past(LNK_IN_TOKEN)) else $error("stray nak");
    a_nak_int_set: assert property (LNK_NAK && NAK_INT_EN && !EP_ISO
        && !CPU_INT_CLR |-> ##[0:2] EP_INT) else $error("nak without int");
    a_int_sticky: assert property (EP_INT && !CPU_INT_CLR |=> EP_INT)
        else $error("interrupt dropped");
    a_iso_no_int: assert property (EP_ISO && !EP_INT |=> !EP_INT)
        else $error("iso raised interrupt");
    a_iso_no_nak: assert property (EP_ISO |-> !LNK_NAK)
        else $error("iso refused");
    a_zlp_cause: assert property (LNK_IN_ZLP |-> $past(LNK_IN_TOKEN) ||
        $past(FRAME_TICK) || $past(FRAME_TICK, 2)) else $error("stray zlp");
    a_in_burst: assert property (s_mid_byte |=> LNK_IN_VALID)
        else $error("gap in packet");
    a_last_valid: assert property (LNK_IN_LAST |-> LNK_IN_VALID)
        else $error("last without byte");
    a_status_hold: assert property (!$past(CPU_CMD_QUERY) |->
        $stable(CPU_STATUS)) else $error("status moved");
endmodule : usbdb_chk

bind usbdb_top usbdb_chk u_usbdb_chk (.CLK_SYS, .RESETN, .EP_ISO, .EP_DIR_IN,
    .NAK_INT_EN, .FRAME_TICK, .LNK_OUT_START, .LNK_IN_TOKEN, .CPU_CMD_QUERY,
    .CPU_INT_CLR, .LNK_ACK, .LNK_NAK, .LNK_IN_VALID, .LNK_IN_LAST,
    .LNK_IN_ZLP, .CPU_STATUS, .EP_INT);
`default_nettype wire

// >>> test/usbdb_host.sv
// Host-side link model: sends OUT packets and issues IN tokens
`timescale 1ns/100ps
`default_nettype none
module usbdb_host (
    input  wire logic       clk,
    input  wire logic       ready,
    input  wire logic       ack,
    input  wire logic       nak,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    input  wire logic       in_last,
    output logic            start,
    output logic            valid,
    output logic      [7:0] data,
    output logic            last,
    output logic            token,
    output logic            done
);
    initial {start, valid, data, last, token, done} = '0;

    // ************************************************************
    // OUT packet: bytes base, base+1, ...; each held until ready
    // ************************************************************
    task automatic send_out(input int n, input logic [7:0] base,
                            output logic got_ack, output logic got_nak);
        int w;
        got_ack = 1'b0;
        got_nak = 1'b0;
        @(posedge clk);
        #1 start = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            valid = 1'b1;
            data = base + 8'(i);
            last = (i == n - 1);
            w = 0;
            do
            begin
                @(posedge clk);
                got_ack |= ack;
                got_nak |= nak;
                w++;
            end while (!ready && w < 50);
            #1 start = 1'b0;
        end
        {valid, last} = 2'b00;
        data = ~data;   // Released bus shows the inverse, not stale data
        // Leave room for the last byte to drain into its slot
        repeat (4)
        begin
            @(posedge clk);
            got_ack |= ack;
            got_nak |= nak;
        end
        #1;             // Hand back off the edge so outputs are settled
    endtask : send_out

    // ************************************************************
    // IN token: collect the answer, acknowledge any data packet
    // ************************************************************
    task automatic in_token(output logic got_nak, output int n,
                            output logic [7:0] b [8]);
        int w;
        got_nak = 1'b0;
        n = 0;
        w = 0;
        @(posedge clk);
        #1 token = 1'b1;
        @(posedge clk);
        #1 token = 1'b0;
        // Bounded wait so a silent device cannot hang the run
        while (w < 20)
        begin
            @(posedge clk);
            w++;
            got_nak |= nak;
            if (in_valid)
            begin
                b[n[2:0]] = in_data;
                n++;
                if (in_last) w = 99;
            end
        end
        #1 if (n > 0)
        begin
            done = 1'b1;
            @(posedge clk);
            #1 done = 1'b0;
        end
    endtask : in_token
endmodule : usbdb_host
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the double-buffered endpoint block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import usbdb_pkg::*;
    logic             clk = 1'b0, rst_n = 1'b0, iso = 1'b0, dir_in = 1'b0;
    logic             nak_en = 1'b0, frame = 1'b0, wr = 1'b0, rd = 1'b0;
    logic             rel = 1'b0, com = 1'b0, qry = 1'b0, clr = 1'b0;
    logic [7:0]       wdata = 8'h00, h_data, idata, rdata, status;
    logic             h_start, h_valid, h_last, h_token, h_done;
    logic             ready, ack, nak, ivalid, ilast, zlp, ep_int;
    logic             zlp_seen = 1'b0;
    logic [LEN_W-1:0] rlen;
    int               err_total = 0, n_tests = 0;

    always #25 clk = ~clk;      // 20 MHz system clock
    always @(posedge clk) zlp_seen <= rst_n & (zlp_seen | zlp);

    usbdb_top u_usbdb_top (.CLK_SYS(clk), .RESETN(rst_n), .EP_ISO(iso),
        .EP_DIR_IN(dir_in), .NAK_INT_EN(nak_en), .FRAME_TICK(frame),
        .LNK_OUT_START(h_start), .LNK_OUT_VALID(h_valid),
        .LNK_OUT_DATA(h_data), .LNK_OUT_LAST(h_last), .LNK_OUT_READY(ready),
        .LNK_IN_TOKEN(h_token), .LNK_IN_DONE(h_done), .LNK_IN_FAIL(1'b0),
        .LNK_ACK(ack), .LNK_NAK(nak), .LNK_IN_VALID(ivalid),
        .LNK_IN_DATA(idata), .LNK_IN_LAST(ilast), .LNK_IN_ZLP(zlp),
        .CPU_WR(wr), .CPU_WDATA(wdata), .CPU_RD(rd), .CPU_RDATA(rdata),
        .CPU_RLEN(rlen), .CPU_CMD_RELEASE(rel), .CPU_CMD_COMMIT(com),
        .CPU_CMD_QUERY(qry), .CPU_STATUS(status), .CPU_INT_CLR(clr),
        .EP_INT(ep_int));
    usbdb_host u_usbdb_host (.clk(clk), .ready(ready), .ack(ack), .nak(nak),
        .in_valid(ivalid), .in_data(idata), .in_last(ilast), .start(h_start),
        .valid(h_valid), .data(h_data), .last(h_last), .token(h_token),
        .done(h_done));

    // ************************************************************
    // Compare, report and CPU-side helpers
    // ************************************************************
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // One-cycle CPU pulse; returns once the registered answer has landed
    task automatic cpu(input int op, input logic [7:0] d);
        @(posedge clk);
        #1;
        case (op)
            0: {wr, wdata} = {1'b1, d};
            1: rd = 1'b1;
            2: rel = 1'b1;
            3: com = 1'b1;
            4: qry = 1'b1;
            5: clr = 1'b1;
            default: frame = 1'b1;
        endcase
        @(posedge clk);
        #1 {wr, rd, rel, com, qry, clr, frame} = '0;
    endtask : cpu
    task automatic qchk(input logic [7:0] exp);
        cpu(4, 8'h00);
        chk_byte({4'h0, status[3:0]}, exp);
    endtask : qchk
    // Mode pins iso and dir_in only change while the block is held in reset; nak_en is cleared here and set later by t_bulk_in
    task automatic reset_dut(input logic i, input logic d);
        {rst_n, iso, dir_in, nak_en} = {1'b0, i, d, 1'b0};
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask : reset_dut

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_bulk_out;
        logic a, n;
        reset_dut(1'b0, 1'b0);
        qchk(STATUS_RST);
        chk_bit(ready, 1'b1);
        u_usbdb_host.send_out(3, 8'h10, a, n);
        chk_bit(a, 1'b1);
        chk_bit(ep_int, 1'b1);
        qchk(8'h09);
        cpu(5, 8'h00);
        u_usbdb_host.send_out(2, 8'h20, a, n);
        chk_bit(ep_int & a, 1'b1);
        cpu(5, 8'h00);
        // Third packet with both slots full is refused
        u_usbdb_host.send_out(2, 8'h30, a, n);
        chk_bit(n & ~a, 1'b1);
        chk_bit(ep_int, 1'b0);
        qchk(8'h05);
        for (int i = 0; i < 3; i++)
        begin
            cpu(1, 8'h00);
            chk_byte(rdata, 8'h10 + 8'(i));
        end
        chk_byte(8'(rlen), 8'h03);
        cpu(2, 8'h00);
        qchk(8'h03);
        cpu(6, 8'h00);
        qchk(8'h03);
        cpu(1, 8'h00);
        chk_byte(rdata, 8'h20);
        cpu(2, 8'h00);
        qchk(8'h00);
        u_usbdb_host.send_out(1, 8'h40, a, n);
        qchk(8'h09);
        $display("test bulk_out finished");
    endtask : t_bulk_out

    task automatic t_bulk_in;
        logic       n;
        int         cnt;
        logic [7:0] b [8];
        reset_dut(1'b0, 1'b1);
        u_usbdb_host.in_token(n, cnt, b);
        chk_bit(n, 1'b1);
        chk_bit(ep_int, 1'b0);
        nak_en = 1'b1;
        u_usbdb_host.in_token(n, cnt, b);
        chk_bit(n & ep_int, 1'b1);
        cpu(5, 8'h00);
        cpu(0, 8'hA0);
        cpu(0, 8'hA1);
        cpu(3, 8'h00);
        qchk(8'h06);
        cpu(0, 8'hB0);
        cpu(3, 8'h00);
        qchk(8'h05);
        u_usbdb_host.in_token(n, cnt, b);
        chk_byte(8'(cnt), 8'h02);
        chk_byte(b[0] ^ b[1], 8'h01);
        chk_byte(b[0], 8'hA0);
        qchk(8'h0C);
        cpu(5, 8'h00);
        u_usbdb_host.in_token(n, cnt, b);
        chk_byte(b[0], 8'hB0);
        qchk(8'h08);
        $display("test bulk_in finished");
    endtask : t_bulk_in

    task automatic t_iso;
        logic a, n;
        reset_dut(1'b1, 1'b0);
        u_usbdb_host.send_out(2, 8'h50, a, n);
        chk_bit(a, 1'b1);
        chk_bit(ep_int, 1'b0);
        qchk(8'h04);
        cpu(2, 8'h00);
        qchk(8'h04);
        cpu(6, 8'h00);
        qchk(8'h03);
        cpu(1, 8'h00);
        chk_byte(rdata, 8'h50);
        cpu(6, 8'h00);
        qchk(8'h00);
        reset_dut(1'b1, 1'b1);
        cpu(6, 8'h00);
        repeat (2) @(posedge clk);
        chk_bit(zlp_seen, 1'b1);
        $display("test iso finished");
    endtask : t_iso

    initial
    begin
        t_bulk_out();
        t_bulk_in();
        t_iso();
        tally_and_finish();
    end
    // Watchdog: a stuck run counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
